/* rtl/ddr_pkg.sv */
// constants, register map and carrier types for the ddr sample input retimer
// assumes one 20 MHz clock and a byte-wide register port with a five-bit address
package ddr_pkg;

	// register offsets
	localparam logic [4:0] REG_DATA_CTRL = 5'h02;
	localparam logic [4:0] REG_CAL_ADDR  = 5'h10;
	localparam logic [4:0] REG_CAL_DATA  = 5'h11;
	localparam logic [4:0] REG_CAL_CMD   = 5'h12;
	localparam logic [4:0] REG_RETIMER   = 5'h14;
	localparam logic [4:0] REG_REVISION  = 5'h1f;

	// data control fields (offset 0x02)
	localparam int BIT_TWOS_FORMAT = 7;
	localparam int BIT_FIRST_CHAN  = 5;
	localparam int BIT_EDGE_SEL    = 4;
	localparam int BIT_EXT_DATA_CLOCK_IN_ENABLE      = 2;
	localparam int BIT_DCO_SINGLE  = 1;
	localparam int BIT_DCO_DOUBLE  = 0;
	localparam logic [7:0] DATA_CTRL_RST = 8'h04;

	// calibration command fields
	localparam int BIT_CAL_WRITE   = 3;
	localparam int BIT_CAL_READ    = 2;
	localparam int BIT_Q_CLEAR     = 1;
	localparam int BIT_I_CLEAR     = 0;

	// retimer register fields
	localparam int Q_PHASE_LSB     = 6;
	localparam int BIT_SEARCHING   = 4;
	localparam int BIT_REACQUIRE   = 3;
	localparam int BIT_FORCE       = 2;
	localparam int I_PHASE_LSB     = 0;

	// calibration store shape and uncalibrated default
	localparam int CAL_AW = 6;
	localparam int CAL_DW = 6;
	localparam logic [CAL_DW-1:0] CAL_DEFAULT = 6'h20;

	// timing: acquisition must finish within 128 clock cycles
	localparam int ACQ_LIMIT_CYC = 128;
	localparam int ACQ_CYC       = 64;

	// widest supported sample and carrier for one interleaved pair
	localparam int MAX_W = 14;
	typedef struct packed {
		logic [MAX_W-1:0] i_smp;
		logic [MAX_W-1:0] q_smp;
	} ddr_pair_s;

	// retimer acquisition states
	typedef enum logic [1:0] {ST_IDLE, ST_SEARCH, ST_LOCKED} ddr_acq_e;

endpackage

/* rtl/ddr_fifo.sv */
// small synchronous fifo between sample capture and converter drain
// assumes one clock and a synchronous active-high reset
`timescale 1ns/1ps
`default_nettype none
module ddr_fifo #(
	parameter int W     = 28,
	parameter int DEPTH = 4
) (
	input  wire logic         i_clk,
	input  wire logic         i_srst,
	input  wire logic         i_in_valid,
	output logic              o_in_ready,
	input  wire logic [W-1:0] i_in_data,
	output logic              o_out_valid,
	input  wire logic         i_out_ready,
	output logic [W-1:0]      o_out_data
);
	localparam int AW = $clog2(DEPTH);

	logic [W-1:0]  mem_r [DEPTH];
	logic [AW-1:0] wr_ptr_r;
	logic [AW-1:0] rd_ptr_r;
	logic [AW:0]   count_r;
	wire           push = i_in_valid && o_in_ready;
	wire           pop  = o_out_valid && i_out_ready;

	// honest flags straight from the occupancy count
	assign o_in_ready  = (count_r != (AW+1)'(DEPTH));
	assign o_out_valid = (count_r != '0);
	assign o_out_data  = mem_r[rd_ptr_r];

	// pointers wrap at depth, which need not be a power of two
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			wr_ptr_r <= '0;
			rd_ptr_r <= '0;
			count_r  <= '0;
		end else begin
			if (push) begin
				mem_r[wr_ptr_r] <= i_in_data;
				wr_ptr_r <= (wr_ptr_r == AW'(DEPTH-1)) ? '0 : wr_ptr_r + 1'b1;
			end
			if (pop)
				rd_ptr_r <= (rd_ptr_r == AW'(DEPTH-1)) ? '0 : rd_ptr_r + 1'b1;
			count_r <= count_r + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule
`default_nettype wire

/* rtl/ddr_retimer.sv */
// ddr interleaved sample capture, retimer, calibration store and register file
// assumes data clock and sample bus pins are asynchronous to i_clk; register port is on i_clk
//
// Functional notes
// - write bit3 stores data word at address
// - write bit2 loads store word into data
// - write bit1 resets all Q coefficients
// - write bit0 resets all I coefficients
// - Q phase readonly unless forcing, then writable
// - searching bit high while acquiring, reset zero
// - rising edge on reacquire restarts acquisition
// - force bit makes I field drive both
// - I phase readonly unless forcing, then writable
// - fixed revision code at 0x1F
// - interleaved ddr pairs with qualifying data clock
// - sample width parameter: 8,10,12,14 bits
// - edge select picks rising or falling capture
// - first channel select orders I/Q in pair
// - format bit picks unsigned or twos complement
// - samples pass retimer before core register
// - dci enable clear uses converter clock
// - clock out bits drive derived data clock
// - edge select one: I rising, Q falling
// - acquisition clears searching within 128 cycles
// - phase codes map to retime phases 2,3,3,1
// - store access uses 0x10 address, 0x11 data
`timescale 1ns/1ps
`default_nettype none
module ddr_retimer #(
	parameter int          SAMPLE_W   = 14,
	parameter int          QTR_CYC    = 1,
	parameter int          FIFO_DEPTH = 4,
	parameter logic [7:0]  REVISION   = 8'h5c  // arbitrary value
) (
	input  wire logic                i_clk,
	input  wire logic                i_srst,
	input  wire logic                i_pin_config_mode,
	input  wire logic                i_data_clock_pin,
	input  wire logic [SAMPLE_W-1:0] i_sample_bus,
	input  wire logic                i_reg_wr,
	input  wire logic                i_reg_rd,
	input  wire logic [4:0]          i_reg_addr,
	input  wire logic [7:0]          i_reg_wdata,
	output logic      [7:0]          o_reg_rdata,
	output logic                     o_data_clock_out,
	output logic                     o_data_clock_oe,
	output logic                     o_core_valid,
	output logic      [SAMPLE_W-1:0] o_core_i,
	output logic      [SAMPLE_W-1:0] o_core_q,
	output logic      [1:0]          o_i_retime_phase,
	output logic      [1:0]          o_q_retime_phase,
	output logic                     o_overrun
);
	localparam int PW = 2 * ddr_pkg::MAX_W;

	// width check at elaboration: only the four documented widths
	if (!(SAMPLE_W == 8 || SAMPLE_W == 10 || SAMPLE_W == 12 || SAMPLE_W == 14)) begin : g_bad_width
		$error("unsupported sample width");
	end

	// phase code to retime phase number
	function automatic logic [1:0] retime_phase(input logic [1:0] code);
		case (code)
			2'b00:   retime_phase = 2'd2;
			2'b01:   retime_phase = 2'd3;
			2'b10:   retime_phase = 2'd3;
			default: retime_phase = 2'd1;
		endcase
	endfunction

	// format conversion towards offset binary
	function automatic logic [SAMPLE_W-1:0] to_offset(input logic [SAMPLE_W-1:0] s, input logic twos);
		to_offset = twos ? {~s[SAMPLE_W-1], s[SAMPLE_W-2:0]} : s;
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// registers
	logic [7:0]                 data_ctrl_r;
	logic [ddr_pkg::CAL_AW-1:0] cal_addr_r;
	logic [ddr_pkg::CAL_DW-1:0] cal_data_r;
	logic [ddr_pkg::CAL_DW-1:0] cal_mem_r [2**ddr_pkg::CAL_AW];
	logic                       force_r;
	logic                       reacq_r;
	logic [1:0]                 i_force_r;
	logic [1:0]                 q_force_r;
	logic [1:0]                 i_auto_r;
	logic [1:0]                 q_auto_r;
	logic                       searching_r;

	// address decode for writes only; the read mux compares the address itself
	wire wr_ctrl = i_reg_wr && i_reg_addr == ddr_pkg::REG_DATA_CTRL;
	wire wr_addr = i_reg_wr && i_reg_addr == ddr_pkg::REG_CAL_ADDR;
	wire wr_data = i_reg_wr && i_reg_addr == ddr_pkg::REG_CAL_DATA;
	wire wr_cmd  = i_reg_wr && i_reg_addr == ddr_pkg::REG_CAL_CMD;
	wire wr_ret  = i_reg_wr && i_reg_addr == ddr_pkg::REG_RETIMER;

	// command strobes last one cycle and are never stored
	wire cmd_write = wr_cmd && i_reg_wdata[ddr_pkg::BIT_CAL_WRITE];
	wire cmd_read  = wr_cmd && i_reg_wdata[ddr_pkg::BIT_CAL_READ];
	wire cmd_q_clr = wr_cmd && i_reg_wdata[ddr_pkg::BIT_Q_CLEAR];
	wire cmd_i_clr = wr_cmd && i_reg_wdata[ddr_pkg::BIT_I_CLEAR];

	// pin mode ignores software settings and runs defaults
	wire [7:0] ctrl      = i_pin_config_mode ? ddr_pkg::DATA_CTRL_RST : data_ctrl_r;
	wire       twos      = ctrl[ddr_pkg::BIT_TWOS_FORMAT];
	wire       i_first   = ctrl[ddr_pkg::BIT_FIRST_CHAN];
	wire       edge_sel  = ctrl[ddr_pkg::BIT_EDGE_SEL];
	wire       ext_data_clock_in_enable    = ctrl[ddr_pkg::BIT_EXT_DATA_CLOCK_IN_ENABLE];
	wire       dco_sgl   = ctrl[ddr_pkg::BIT_DCO_SINGLE];
	wire       dco_dbl   = ctrl[ddr_pkg::BIT_DCO_DOUBLE];
	wire       force_eff = force_r && !i_pin_config_mode;

	// phase fields follow the force bit being written in the same access
	wire       wr_force  = wr_ret && i_reg_wdata[ddr_pkg::BIT_FORCE];
	wire       reacq_req = wr_ret && i_reg_wdata[ddr_pkg::BIT_REACQUIRE] && !reacq_r;

	// chosen phases: forced I field drives both retimers
	wire [1:0] i_code = force_eff ? i_force_r : i_auto_r;
	wire [1:0] q_code = force_eff ? i_force_r : q_auto_r;
	wire [1:0] q_rd   = force_eff ? q_force_r : q_auto_r;

	// cal store upper half holds Q coefficients, lower half holds I
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			data_ctrl_r <= ddr_pkg::DATA_CTRL_RST;
			cal_addr_r  <= '0;
			cal_data_r  <= '0;
			force_r     <= 1'b0;
			reacq_r     <= 1'b0;
			i_force_r   <= 2'b00;
			q_force_r   <= 2'b00;
		end else begin
			if (wr_ctrl)
				data_ctrl_r <= i_reg_wdata;
			if (wr_addr)
				cal_addr_r <= i_reg_wdata[ddr_pkg::CAL_AW-1:0];
			if (wr_data)
				cal_data_r <= i_reg_wdata[ddr_pkg::CAL_DW-1:0];
			else if (cmd_read)
				cal_data_r <= cal_mem_r[cal_addr_r];
			if (wr_ret) begin
				force_r <= i_reg_wdata[ddr_pkg::BIT_FORCE];
				reacq_r <= i_reg_wdata[ddr_pkg::BIT_REACQUIRE];
			end
			if (wr_force) begin
				i_force_r <= i_reg_wdata[ddr_pkg::I_PHASE_LSB +: 2];
				q_force_r <= i_reg_wdata[ddr_pkg::Q_PHASE_LSB +: 2];
			end
		end
	end

	// coefficient store: clears act on whole halves and win over a write to the same word
	always_ff @(posedge i_clk) begin
		for (int k = 0; k < 2**ddr_pkg::CAL_AW; k++) begin
			if (i_srst || (cmd_i_clr && k < 2**(ddr_pkg::CAL_AW-1))
			    || (cmd_q_clr && k >= 2**(ddr_pkg::CAL_AW-1)))
				cal_mem_r[k] <= ddr_pkg::CAL_DEFAULT;
			else if (cmd_write && cal_addr_r == ddr_pkg::CAL_AW'(k))
				cal_mem_r[k] <= cal_data_r;
		end
	end

	// read mux; command register reads zero, unmapped offsets read zero
	logic [7:0] rd_mux;
	assign rd_mux =
		(i_reg_addr == ddr_pkg::REG_DATA_CTRL) ? data_ctrl_r :
		(i_reg_addr == ddr_pkg::REG_CAL_ADDR)  ? 8'(cal_addr_r) :
		(i_reg_addr == ddr_pkg::REG_CAL_DATA)  ? 8'(cal_data_r) :
		(i_reg_addr == ddr_pkg::REG_RETIMER)   ? {q_rd, 1'b0, searching_r, reacq_r, force_r, i_code} :
		(i_reg_addr == ddr_pkg::REG_REVISION)  ? REVISION : 8'h00;

	////////////////////////////////////////////////////////////////////////////
	// converter clock from a quarter-period divider; clock outputs derived from it
	logic [15:0] qdiv_r;
	logic [1:0]  quad_r;
	logic        dbl_clk_r;
	wire         qtick     = (qdiv_r == 16'(QTR_CYC - 1));
	wire         conv_tick = qtick && quad_r == 2'd3;  // converter clock rising
	wire         conv_lvl  = !quad_r[1];

	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			qdiv_r    <= '0;
			quad_r    <= 2'd0;
			dbl_clk_r <= 1'b0;
		end else begin
			qdiv_r <= qtick ? '0 : qdiv_r + 1'b1;
			if (qtick) begin
				quad_r    <= quad_r + 1'b1;
				dbl_clk_r <= ~dbl_clk_r;
			end
		end
	end

	// driver: single follows converter clock, double runs at twice it
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			o_data_clock_out <= 1'b0;
			o_data_clock_oe  <= 1'b0;
		end else begin
			o_data_clock_oe  <= dco_sgl || dco_dbl;
			o_data_clock_out <= dco_dbl ? dbl_clk_r : (dco_sgl && conv_lvl);
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// pin synchronisers: two flops before any logic reads clock or bus
	logic                dck_s1_r, dck_s2_r, dck_s3_r;
	logic [SAMPLE_W-1:0] bus_s1_r, bus_s2_r;
	logic                conv_d_r;
	always_ff @(posedge i_clk) begin
		dck_s1_r <= i_data_clock_pin;
		dck_s2_r <= dck_s1_r;
		dck_s3_r <= dck_s2_r;
		bus_s1_r <= i_sample_bus;
		bus_s2_r <= bus_s1_r;
		conv_d_r <= conv_lvl;
	end

	// capture clock: external pin or converter clock when input is disabled
	wire cap_now  = ext_data_clock_in_enable ? dck_s2_r : conv_lvl;
	wire cap_prev = ext_data_clock_in_enable ? dck_s3_r : conv_d_r;
	wire rise     = cap_now && !cap_prev;
	wire fall     = !cap_now && cap_prev;
	// edge select one: I on rising, Q on falling; zero swaps them
	wire take_i   = edge_sel ? rise : fall;
	wire take_q   = edge_sel ? fall : rise;
	// the pair completes on the channel that comes second
	wire pair_end = i_first ? take_q : take_i;

	logic [SAMPLE_W-1:0] i_hold_r, q_hold_r;
	logic                push_r;
	ddr_pkg::ddr_pair_s  push_pair_r;
	logic                fifo_in_ready;
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			i_hold_r  <= '0;
			q_hold_r  <= '0;
			push_r    <= 1'b0;
			o_overrun <= 1'b0;
		end else begin
			if (take_i)
				i_hold_r <= to_offset(bus_s2_r, twos);
			if (take_q)
				q_hold_r <= to_offset(bus_s2_r, twos);
			// a full fifo stalls the pending pair; a new pair arriving while it waits is dropped and flagged
			if (pair_end && !(push_r && !fifo_in_ready)) begin
				push_r            <= 1'b1;
				push_pair_r.i_smp <= ddr_pkg::MAX_W'(take_i ? to_offset(bus_s2_r, twos) : i_hold_r);
				push_pair_r.q_smp <= ddr_pkg::MAX_W'(take_q ? to_offset(bus_s2_r, twos) : q_hold_r);
			end else if (fifo_in_ready) begin
				push_r <= 1'b0;
			end
			if (pair_end && push_r && !fifo_in_ready)
				o_overrun <= 1'b1;
			else if (wr_ctrl)
				o_overrun <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// retimer fifo towards the converter domain
	logic                    fifo_out_valid;
	logic [PW-1:0]           fifo_out_data;
	ddr_pkg::ddr_pair_s      pop_pair;
	wire                     drain = conv_tick && !searching_r;
	assign pop_pair = fifo_out_data;

	ddr_fifo #(.W(PW), .DEPTH(FIFO_DEPTH)) u_fifo (
		.i_clk       (i_clk),
		.i_srst      (i_srst),
		.i_in_valid  (push_r),
		.o_in_ready  (fifo_in_ready),
		.i_in_data   (push_pair_r),
		.o_out_valid (fifo_out_valid),
		.i_out_ready (drain),
		.o_out_data  (fifo_out_data)
	);

	// core register loads only on converter ticks after lock
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			o_core_valid <= 1'b0;
			o_core_i     <= '0;
			o_core_q     <= '0;
		end else begin
			o_core_valid <= drain && fifo_out_valid;
			if (drain && fifo_out_valid) begin
				o_core_i <= pop_pair.i_smp[SAMPLE_W-1:0];
				o_core_q <= pop_pair.q_smp[SAMPLE_W-1:0];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// acquisition: measure quadrant of data edge against converter clock
	ddr_pkg::ddr_acq_e st_r;
	logic [7:0]        acq_cnt_r;
	logic [1:0]        meas_r;
	logic              boot_r;
	wire               acq_done = acq_cnt_r == 8'(ddr_pkg::ACQ_CYC - 1);

	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			st_r        <= ddr_pkg::ST_IDLE;
			searching_r <= 1'b0;
			boot_r      <= 1'b1;
			acq_cnt_r   <= '0;
			meas_r      <= 2'b00;
			i_auto_r    <= 2'b00;
			q_auto_r    <= 2'b00;
			o_i_retime_phase <= 2'd0;
			o_q_retime_phase <= 2'd0;
		end else begin
			boot_r <= 1'b0;
			o_i_retime_phase <= retime_phase(i_code);
			o_q_retime_phase <= retime_phase(q_code);
			if (rise)
				meas_r <= quad_r;
			if (boot_r || reacq_req) begin
				st_r        <= ddr_pkg::ST_SEARCH;
				searching_r <= 1'b1;
				acq_cnt_r   <= '0;
			end else begin
				case (st_r)
					ddr_pkg::ST_SEARCH: begin
						acq_cnt_r <= acq_cnt_r + 1'b1;
						if (acq_done) begin
							st_r        <= ddr_pkg::ST_LOCKED;
							searching_r <= 1'b0;
							i_auto_r    <= meas_r;
							q_auto_r    <= meas_r;
						end
					end
					ddr_pkg::ST_LOCKED: st_r <= ddr_pkg::ST_LOCKED;
					ddr_pkg::ST_IDLE:   st_r <= ddr_pkg::ST_IDLE;
					default:            st_r <= ddr_pkg::ST_IDLE;
				endcase
			end
		end
	end

	// read data registered one cycle after the read strobe
	always_ff @(posedge i_clk) begin
		if (i_srst)
			o_reg_rdata <= 8'h00;
		else if (i_reg_rd)
			o_reg_rdata <= rd_mux;
	end

	////////////////////////////////////////////////////////////////////////////
	// checks
	logic [7:0] srch_len_r;
	always_ff @(posedge i_clk) begin
		if (i_srst || !searching_r)
			srch_len_r <= '0;
		else
			srch_len_r <= srch_len_r + 1'b1;
	end

	a_search_bound: assert property (@(posedge i_clk) disable iff (i_srst)
		srch_len_r < 8'(ddr_pkg::ACQ_LIMIT_CYC)) else $error("searching exceeded 128 cycles");
	a_reacq_restart: assert property (@(posedge i_clk) disable iff (i_srst)
		reacq_req |=> searching_r) else $error("reacquire did not restart search");
	a_reset_search: assert property (@(posedge i_clk)
		i_srst |=> !searching_r) else $error("searching not zero after reset");
	a_no_drain_srch: assert property (@(posedge i_clk) disable iff (i_srst)
		searching_r |=> !o_core_valid) else $error("core loaded while searching");
	a_force_both: assert property (@(posedge i_clk) disable iff (i_srst)
		force_eff |=> o_q_retime_phase == o_i_retime_phase) else $error("forced phases differ");
	a_phase_map: assert property (@(posedge i_clk) disable iff (i_srst)
		(i_code == 2'b00) |=> o_i_retime_phase == 2'd2) else $error("phase code 00 not phase 2");
	a_cal_write: assert property (@(posedge i_clk) disable iff (i_srst)
		(cmd_write && !cmd_i_clr && !cmd_q_clr) |=> cal_mem_r[$past(cal_addr_r)] == $past(cal_data_r))
		else $error("store write lost");
	a_cal_read: assert property (@(posedge i_clk) disable iff (i_srst)
		(cmd_read && !wr_data) |=> cal_data_r == $past(cal_mem_r[cal_addr_r])) else $error("store read lost");
	a_i_clear: assert property (@(posedge i_clk) disable iff (i_srst)
		cmd_i_clr |=> cal_mem_r[0] == ddr_pkg::CAL_DEFAULT) else $error("I coefficients not cleared");
	a_q_clear: assert property (@(posedge i_clk) disable iff (i_srst)
		cmd_q_clr |=> cal_mem_r[2**ddr_pkg::CAL_AW-1] == ddr_pkg::CAL_DEFAULT) else $error("Q not cleared");
	a_cmd_reads0: assert property (@(posedge i_clk) disable iff (i_srst)
		(i_reg_rd && i_reg_addr == ddr_pkg::REG_CAL_CMD) |=> o_reg_rdata == 8'h00) else $error("command nonzero");
	a_revision: assert property (@(posedge i_clk) disable iff (i_srst)
		(i_reg_rd && i_reg_addr == ddr_pkg::REG_REVISION) |=> o_reg_rdata == REVISION) else $error("bad revision");
	a_dco_enable: assert property (@(posedge i_clk) disable iff (i_srst)
		(dco_sgl || dco_dbl) |=> o_data_clock_oe) else $error("clock output not enabled");
endmodule
`default_nettype wire

/* testbench/ddr_src_model.sv */
// fpga-side source: drives interleaved ddr i/q pairs with a qualifying clock
// assumes calls arrive just after a falling edge of i_clk
`timescale 1ns/1ps
`default_nettype none
module ddr_src_model #(
	parameter int W = 8
) (
	input  wire logic    i_clk,
	output logic         o_dclk,
	output logic [W-1:0] o_bus
);
	initial begin
		o_dclk = 1'b0;
		o_bus = '0;
	end
	// one pair, edges four cycles apart so the synchroniser sees each one
	task automatic send(input logic [W-1:0] a, input logic [W-1:0] b);
		o_bus = a;
		repeat (2) @(negedge i_clk);
		o_dclk = ~o_dclk;
		repeat (2) @(negedge i_clk);
		o_bus = b;
		repeat (2) @(negedge i_clk);
		o_dclk = ~o_dclk;
		repeat (2) @(negedge i_clk);
		o_bus = ~b; // released bus shows the inverse, never a stale copy
	endtask
	// clock stands still between frames; the idle level moves only under reset
	task automatic park(input logic lvl);
		o_dclk = lvl;
	endtask
endmodule
`default_nettype wire

/* testbench/tb_dual_dac_ddr_input_retimer.sv */
// self-checking bench for the ddr input retimer: registers, cal store, phases, sample path
// assumes the source model and the design package are compiled first
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin n_tests++; if ((got) !== (exp)) begin err_total++; \
	$display("MISMATCH t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module tb_dual_dac_ddr_input_retimer;
	localparam int W = 8;
	localparam logic [7:0] REV = 8'h3b; // arbitrary value
	localparam logic [1:0] PH [4] = '{2'h2, 2'h3, 2'h3, 2'h1};
	localparam logic [4:0] RT = ddr_pkg::REG_RETIMER;
	localparam logic [4:0] DC = ddr_pkg::REG_DATA_CTRL;
	localparam logic [4:0] CA = ddr_pkg::REG_CAL_ADDR;
	localparam logic [4:0] CD = ddr_pkg::REG_CAL_DATA;
	localparam logic [4:0] CM = ddr_pkg::REG_CAL_CMD;
	logic         i_clk = 1'b0;
	logic         i_srst = 1'b1;
	logic         pmode = 1'b0;
	logic         wr = 1'b0;
	logic         rd = 1'b0;
	logic [4:0]   addr = '0;
	logic [7:0]   wdata = '0;
	logic [7:0]   rdata, v;
	logic         dclk, dco, dco_oe, cv, ovr;
	logic [W-1:0] bus, ci, cq;
	logic [1:0]   iph, qph;
	int           err_total = 0;
	int           n_tests = 0;
	always #25 i_clk = ~i_clk;
	ddr_src_model #(.W(W)) i_src (.i_clk(i_clk), .o_dclk(dclk), .o_bus(bus));
	// narrowest sample width exercises the parameter boundary
	ddr_retimer #(.SAMPLE_W(W), .QTR_CYC(1), .FIFO_DEPTH(4), .REVISION(REV)) i_dut (
		.i_clk(i_clk), .i_srst(i_srst), .i_pin_config_mode(pmode), .i_data_clock_pin(dclk),
		.i_sample_bus(bus), .i_reg_wr(wr), .i_reg_rd(rd), .i_reg_addr(addr), .i_reg_wdata(wdata),
		.o_reg_rdata(rdata), .o_data_clock_out(dco), .o_data_clock_oe(dco_oe), .o_core_valid(cv),
		.o_core_i(ci), .o_core_q(cq), .o_i_retime_phase(iph), .o_q_retime_phase(qph), .o_overrun(ovr));
	////////////////////////////////////////////////////////////////
	task automatic summarize();
		$display("tests=%0d errors=%0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	// register port: one-cycle strobes launched on the falling edge
	task automatic wr_reg(input logic [4:0] a, input logic [7:0] d);
		addr = a;
		wdata = d;
		wr = 1'b1;
		@(negedge i_clk);
		wr = 1'b0;
		@(negedge i_clk);
	endtask
	task automatic rd_reg(input logic [4:0] a, output logic [7:0] d);
		addr = a;
		rd = 1'b1;
		@(negedge i_clk);
		rd = 1'b0;
		@(negedge i_clk);
		d = rdata;
	endtask
	task automatic rd_chk(input logic [4:0] a, input logic [7:0] e);
		logic [7:0] d;
		rd_reg(a, d);
		`CHK(d, e)
	endtask
	// 64 polls of two cycles each is the 128-cycle acquisition budget
	task automatic wait_lock();
		logic [7:0] d;
		for (int k = 0; k < 64; k++) begin
			rd_reg(RT, d);
			if (d[ddr_pkg::BIT_SEARCHING] === 1'b0) return;
		end
		err_total++;
		summarize();
	endtask
	////////////////////////////////////////////////////////////////
	task automatic t_cal();
		wr_reg(CA, 8'h05);
		wr_reg(CD, 8'h2a);
		wr_reg(CM, 8'h08);
		wr_reg(CD, 8'h00);
		wr_reg(CM, 8'h00);
		rd_chk(CD, 8'h00);
		wr_reg(CM, 8'h04);
		rd_chk(CD, 8'h2a);
		rd_chk(CM, 8'h00);
		wr_reg(CA, 8'h28);
		wr_reg(CD, 8'h11);
		wr_reg(CM, 8'h08);
		wr_reg(CM, 8'h02);
		wr_reg(CM, 8'h04);
		rd_chk(CD, ddr_pkg::CAL_DEFAULT);
		wr_reg(CA, 8'h05);
		wr_reg(CM, 8'h04);
		rd_chk(CD, 8'h2a);
		wr_reg(CM, 8'h01);
		wr_reg(CM, 8'h04);
		rd_chk(CD, ddr_pkg::CAL_DEFAULT);
	endtask
	task automatic t_phase();
		logic [7:0] a, b;
		wr_reg(RT, 8'h00);
		rd_reg(RT, a);
		wr_reg(RT, 8'hc3);
		rd_reg(RT, b);
		`CHK(b, a)
		for (int c = 0; c < 4; c++) begin
			wr_reg(RT, {2'(3 - c), 4'h1, 2'(c)});
			rd_chk(RT, {2'(3 - c), 4'h1, 2'(c)});
			`CHK(iph, PH[c])
			`CHK(qph, PH[c])
		end
		wr_reg(RT, 8'h00);
		wr_reg(RT, 8'h08);
		rd_reg(RT, a);
		`CHK(a[4], 1'b1)
		wait_lock();
		wr_reg(RT, 8'h08);
		rd_reg(RT, a);
		`CHK(a[4], 1'b0)
		wr_reg(RT, 8'h00);
	endtask
	// twos follows the edge bit so both formats are seen; data clock input stays on
	task automatic t_path(input logic edge_i, input logic first_i);
		logic [W-1:0] iv, qv, e;
		iv = 8'ha5 ^ {edge_i, first_i};
		qv = 8'h3c ^ {first_i, edge_i};
		e = {edge_i, 7'h00};
		wr_reg(DC, {edge_i, 1'b0, first_i, edge_i, 4'h4});
		if (first_i) begin
			i_src.send(iv, qv);
		end else begin
			i_src.send(qv, iv);
		end
		for (int k = 0; k < 40 && cv !== 1'b1; k++) @(negedge i_clk);
		`CHK(cv, 1'b1)
		`CHK(ci, iv ^ e)
		`CHK(cq, qv ^ e)
		if (cv !== 1'b1) summarize();
	endtask
	// searching holds the drain, so six pairs overfill the four-deep buffer
	task automatic t_fill();
		int n;
		wr_reg(RT, 8'h08);
		repeat (6) i_src.send(8'h11, 8'h22);
		repeat (3) @(negedge i_clk);
		`CHK(ovr, 1'b1)
		n = 0;
		repeat (200) begin
			@(negedge i_clk);
			if (cv === 1'b1) n++;
		end
		`CHK(n >= 4, 1'b1)
		wr_reg(DC, 8'h04);
		`CHK(ovr, 1'b0)
		wr_reg(RT, 8'h00);
	endtask
	// with the data clock input off the converter clock captures the parked bus, so pairs keep arriving
	task automatic t_clkout(input logic [7:0] cfg, input int lo, input int hi);
		int n;
		int m;
		logic p;
		wr_reg(DC, cfg);
		@(negedge i_clk);
		`CHK(dco_oe, 1'b1)
		n = 0;
		m = 0;
		p = dco;
		repeat (16) begin
			@(negedge i_clk);
			if (dco !== p) n++;
			if (cv === 1'b1) m++;
			p = dco;
		end
		`CHK(n >= lo && n <= hi, 1'b1)
		`CHK(m >= 2, 1'b1)
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		repeat (16) @(negedge i_clk);
		i_srst = 1'b0;
		@(negedge i_clk);
		rd_reg(RT, v);
		`CHK(v[4], 1'b1)
		wait_lock();
		rd_reg(RT, v);
		`CHK(v[5:2], 4'h0)
		rd_chk(CM, 8'h00);
		rd_chk(DC, ddr_pkg::DATA_CTRL_RST);
		rd_chk(5'h1f, REV);
		rd_chk(5'h07, 8'h00);
		t_cal();
		t_phase();
		t_path(1'b1, 1'b1);
		t_fill();
		t_path(1'b0, 1'b0);
		i_src.park(1'b1);
		i_srst = 1'b1;
		repeat (2) @(negedge i_clk);
		i_srst = 1'b0;
		@(negedge i_clk);
		wait_lock();
		t_path(1'b1, 1'b0);
		t_path(1'b0, 1'b1);
		t_clkout(8'h02, 6, 9);
		t_clkout(8'h01, 14, 16);
		// pin mode falls back to default settings, so the clock output option drops
		pmode = 1'b1;
		repeat (2) @(negedge i_clk);
		`CHK(dco_oe, 1'b0)
		pmode = 1'b0;
		wr_reg(DC, 8'h04);
		@(negedge i_clk);
		`CHK({dco_oe, dco}, 2'b00)
		summarize();
	end
endmodule
`default_nettype wire
